// [rtl/frc_pkg.sv]
package frc_pkg;

  // ---------------------------------------------------------------
  // Command opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_WRITE_LATCH_SET = 8'h06;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_PARAM_READ = 8'h5A;
  localparam logic [7:0] CMD_RESET_ARM = 8'h66;
  localparam logic [7:0] CMD_RESET = 8'h99;

  // ---------------------------------------------------------------
  // Activity codes that select the recovery interval
  // ---------------------------------------------------------------
  localparam logic [2:0] OP_IDLE = 3'h0;
  localparam logic [2:0] OP_READ = 3'h1;
  localparam logic [2:0] OP_PROGRAM = 3'h2;
  localparam logic [2:0] OP_SECTOR_ERASE = 3'h3;
  localparam logic [2:0] OP_BLOCK_ERASE = 3'h4;
  localparam logic [2:0] OP_CHIP_ERASE = 3'h5;
  localparam logic [2:0] OP_STATUS_WRITE = 3'h6;
  localparam logic [2:0] OP_DECODE = 3'h7;

  // ---------------------------------------------------------------
  // Times and cycle counts at the core clock
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int RCV_DECODE_US = 40;
  localparam int RCV_READ_US = 35;
  localparam int RCV_PROGRAM_US = 310;
  localparam int RCV_SECTOR_MS = 12;
  localparam int RCV_BLOCK_MS = 25;
  localparam int RCV_CHIP_MS = 100;
  localparam int RCV_STATUS_MS = 40;
  localparam int RESET_PULSE_MIN_US = 10;
  localparam int RCV_DECODE_CYC = RCV_DECODE_US * CLK_MHZ;
  localparam int RCV_READ_CYC = RCV_READ_US * CLK_MHZ;
  localparam int RCV_PROGRAM_CYC = RCV_PROGRAM_US * CLK_MHZ;
  localparam int RCV_SECTOR_CYC = RCV_SECTOR_MS * 1000 * CLK_MHZ;
  localparam int RCV_BLOCK_CYC = RCV_BLOCK_MS * 1000 * CLK_MHZ;
  localparam int RCV_CHIP_CYC = RCV_CHIP_MS * 1000 * CLK_MHZ;
  localparam int RCV_STATUS_CYC = RCV_STATUS_MS * 1000 * CLK_MHZ;
  localparam int RESET_PULSE_CYC = RESET_PULSE_MIN_US * CLK_MHZ;
  localparam int TMR_W = 22;
  localparam int PULSE_W = 9;

  // ---------------------------------------------------------------
  // Link framing
  // ---------------------------------------------------------------
  localparam logic [3:0] LINK_BYTE_BITS = 4'h8;
  localparam logic [3:0] LINK_STEP_SINGLE = 4'h1;
  localparam logic [3:0] LINK_STEP_QUAD = 4'h4;
  localparam logic [2:0] LINK_BYTE_OPCODE = 3'h0;
  localparam logic [2:0] LINK_BYTE_ADDR_LOW = 3'h3;
  localparam logic [2:0] LINK_BYTE_DUMMY = 3'h4;
  localparam logic [2:0] LINK_BYTE_SAT = 3'h7;
  localparam logic [2:0] LINK_LAST_BIT = 3'h7;

  // Parameter table contents; the values are arbitrary.
  localparam logic [7:0] PARAM_TABLE [8] = '{
    8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88
  };

  // ---------------------------------------------------------------
  // Core state encoding
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_HOLD,
    ST_RECOVER,
    ST_READY
  } frc_state_t;

  // Synchroniser lanes.
  localparam int SYN_CS = 0;
  localparam int SYN_PIN = 1;
  localparam int SYN_POR = 2;
  localparam int SYN_TOG = 3;
  localparam logic [3:0] SYN_RESET = 4'h3;

endpackage

// [rtl/frc_link_if.sv]
`timescale 1ns/100ps
interface frc_link_if;
  logic [7:0] opcode;
  logic op_tog;
  logic multi;

  modport link (output opcode, output op_tog, output multi);
  modport core (input opcode, input op_tog, input multi);
endinterface

// [rtl/frc_timer.sv]
`timescale 1ns/100ps
module frc_timer import frc_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic load_in,
  input wire logic [TMR_W-1:0] count_in,
  output logic running_out
);

  typedef struct packed {
    logic [TMR_W-1:0] cnt;
  } frc_tmr_t;

  frc_tmr_t q, d;

  always_comb begin
    d = q;
    if (load_in) begin
      d.cnt = count_in;
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - TMR_W'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign running_out = (q.cnt != '0);

endmodule

// [rtl/frc_shifter.sv]
`timescale 1ns/100ps
module frc_shifter import frc_pkg::*; (
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic rst_n_in,
  input wire logic quad_in,
  input wire logic [3:0] sio_in,
  output logic so_out,
  output logic so_oe_n_out,
  frc_link_if.link lnk
);

  // Per-frame state is cleared by chip select high, since the link clock
  // stops between frames and no edge would clear it otherwise.
  typedef struct packed {
    logic [3:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic [2:0] idx;
    logic [7:0] sh;
    logic [7:0] tx;
    logic data_phase;
  } frc_frame_t;

  // Frame results must outlive chip select so the core can read them.
  typedef struct packed {
    logic [7:0] opcode;
    logic tog;
    logic multi;
  } frc_keep_t;

  frc_frame_t fq, fd;
  frc_keep_t kq, kd;
  logic so_q;
  logic oe_q;
  logic [3:0] step;
  logic [3:0] cnt;
  logic [7:0] sh_n;

  always_comb begin
    fd = fq;
    kd = kq;
    step = quad_in ? LINK_STEP_QUAD : LINK_STEP_SINGLE;
    sh_n = quad_in ? {fq.sh[3:0], sio_in} : {fq.sh[6:0], sio_in[0]};
    cnt = fq.bit_cnt + step;
    if (fq.data_phase) begin
      if (fq.bit_cnt[2:0] == LINK_LAST_BIT) begin
        fd.bit_cnt = '0;
        fd.tx = PARAM_TABLE[fq.idx];
        fd.idx = fq.idx + 3'h1;
      end else begin
        fd.bit_cnt = fq.bit_cnt + LINK_STEP_SINGLE;
        fd.tx = {fq.tx[6:0], 1'b0};
      end
    end else begin
      fd.sh = sh_n;
      fd.bit_cnt = cnt;
      if (cnt == LINK_BYTE_BITS) begin
        fd.bit_cnt = '0;
        if (fq.byte_cnt != LINK_BYTE_SAT) begin
          fd.byte_cnt = fq.byte_cnt + 3'h1;
        end
        if (fq.byte_cnt == LINK_BYTE_OPCODE) begin
          kd.opcode = sh_n;
          kd.tog = ~kq.tog;
          kd.multi = 1'b0;
        end else begin
          kd.multi = 1'b1;
        end
        if (fq.byte_cnt == LINK_BYTE_ADDR_LOW) begin
          fd.idx = sh_n[2:0];
        end
        // Data starts after three address bytes and one dummy byte.
        if (fq.byte_cnt == LINK_BYTE_DUMMY &&
            kq.opcode == CMD_PARAM_READ) begin
          fd.data_phase = 1'b1;
          fd.tx = PARAM_TABLE[fq.idx];
          fd.idx = fq.idx + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge sclk_in or posedge cs_n_in or negedge rst_n_in) begin
    if (cs_n_in || !rst_n_in) begin
      fq <= '0;
    end else begin
      fq <= fd;
    end
  end

  always_ff @(posedge sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      kq <= '0;
    end else begin
      kq <= kd;
    end
  end

  // Output changes on the falling edge so the host samples on the rise.
  always_ff @(negedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      so_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      so_q <= fq.tx[7];
      oe_q <= fq.data_phase;
    end
  end

  assign so_out = so_q;
  assign so_oe_n_out = ~oe_q;
  assign lnk.opcode = kq.opcode;
  assign lnk.op_tog = kq.tog;
  assign lnk.multi = kq.multi;

endmodule

// [rtl/frc_top.sv]
`timescale 1ns/100ps
module frc_top import frc_pkg::*; #(
  parameter logic [TMR_W-1:0] RCV_PROGRAM_CYCLES = TMR_W'(RCV_PROGRAM_CYC),
  parameter logic [TMR_W-1:0] RCV_SECTOR_CYCLES = TMR_W'(RCV_SECTOR_CYC),
  parameter logic [TMR_W-1:0] RCV_BLOCK_CYCLES = TMR_W'(RCV_BLOCK_CYC),
  parameter logic [TMR_W-1:0] RCV_CHIP_CYCLES = TMR_W'(RCV_CHIP_CYC),
  parameter logic [TMR_W-1:0] RCV_STATUS_CYCLES = TMR_W'(RCV_STATUS_CYC)
) (
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire logic SCLK_IN,
  input wire logic CS_N_IN,
  input wire logic [3:0] SIO_IN,
  output logic SIO1_OUT,
  output logic SIO1_OE_N_OUT,
  input wire logic RESET_PIN_N_IN,
  input wire logic POR_OK_IN,
  input wire logic QUAD_MODE_IN,
  input wire logic CONT_READ_IN,
  input wire logic ENGINE_BUSY_IN,
  input wire logic [2:0] ENGINE_OP_IN,
  input wire logic ERASE_SUSPEND_IN,
  input wire logic PROGRAM_SUSPEND_IN,
  input wire logic ADDR_4BYTE_SET_IN,
  output logic BUSY_FLAG_OUT,
  output logic WRITE_LATCH_FLAG_OUT,
  output logic ERASE_SUSPEND_FLAG_OUT,
  output logic PROGRAM_SUSPEND_FLAG_OUT,
  output logic ADDR_4BYTE_OUT,
  output logic RESET_ARMED_OUT,
  output logic READY_OUT,
  output logic RESUME_OUT,
  output logic ABORT_OUT
);

  // ---------------------------------------------------------------
  // Core state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] stable;
    logic tog_seen;
    logic cs_prev;
    frc_state_t state;
    logic [PULSE_W-1:0] pulse_cnt;
    logic pending;
    logic [7:0] opcode;
    logic armed;
    logic write_latch;
    logic erase_susp;
    logic program_susp;
    logic [2:0] susp_op;
    logic addr4;
    logic busy;
    logic resume_hold;
    logic resume;
    logic abort;
    logic load;
    logic [2:0] rcv_kind;
  } frc_core_t;

  frc_core_t q, d;
  frc_link_if lnk ();
  logic [3:0] raw;
  logic tmr_running;
  logic [TMR_W-1:0] rcv_count;
  logic tog_event;
  logic cs_rise;
  logic cmd_done;
  logic single;
  logic [7:0] cmd;
  logic [2:0] kind;
  logic do_reset;
  logic so_oe_n;

  frc_shifter u_shifter (
    .sclk_in(SCLK_IN),
    .cs_n_in(CS_N_IN),
    .rst_n_in(RST_N_IN),
    .quad_in(QUAD_MODE_IN),
    .sio_in(SIO_IN),
    .so_out(SIO1_OUT),
    .so_oe_n_out(so_oe_n),
    .lnk(lnk.link)
  );

  frc_timer u_timer (
    .clk_in(CLOCK_IN),
    .rst_n_in(RST_N_IN),
    .load_in(q.load),
    .count_in(rcv_count),
    .running_out(tmr_running)
  );

  // ---------------------------------------------------------------
  // Recovery interval lookup
  // ---------------------------------------------------------------
  always_comb begin
    unique case (q.rcv_kind)
      OP_DECODE: rcv_count = TMR_W'(RCV_DECODE_CYC);
      OP_PROGRAM: rcv_count = RCV_PROGRAM_CYCLES;
      OP_SECTOR_ERASE: rcv_count = RCV_SECTOR_CYCLES;
      OP_BLOCK_ERASE: rcv_count = RCV_BLOCK_CYCLES;
      OP_CHIP_ERASE: rcv_count = RCV_CHIP_CYCLES;
      OP_STATUS_WRITE: rcv_count = RCV_STATUS_CYCLES;
      default: rcv_count = TMR_W'(RCV_READ_CYC);
    endcase
  end

  assign raw = {lnk.op_tog, POR_OK_IN, RESET_PIN_N_IN, CS_N_IN};

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.resume = 1'b0;
    d.abort = 1'b0;
    d.load = 1'b0;
    d.s1 = raw;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < 4; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.stable[i] = q.s3[i];
      end
    end
    tog_event = (q.stable[SYN_TOG] != q.tog_seen);
    cs_rise = q.stable[SYN_CS] && !q.cs_prev;
    cmd_done = cs_rise && (q.pending || tog_event);
    cmd = tog_event ? lnk.opcode : q.opcode;
    single = !lnk.multi;
    d.tog_seen = q.stable[SYN_TOG];
    d.cs_prev = q.stable[SYN_CS];
    if (tog_event) begin
      d.pending = 1'b1;
      d.opcode = lnk.opcode;
    end
    if (cs_rise) begin
      d.pending = 1'b0;
    end

    // The erase that is suspended decides the recovery time over anything
    // that may be running while it waits.
    if (q.erase_susp) begin
      kind = q.susp_op;
    end else if (ENGINE_BUSY_IN) begin
      kind = ENGINE_OP_IN;
    end else if (!q.stable[SYN_CS]) begin
      kind = OP_DECODE;
    end else begin
      kind = OP_READ;
    end

    // Pin reset is only honoured once the low level has lasted long
    // enough; shorter glitches are filtered out.
    if (!q.stable[SYN_PIN]) begin
      if (q.pulse_cnt != PULSE_W'(RESET_PULSE_CYC)) begin
        d.pulse_cnt = q.pulse_cnt + PULSE_W'(1);
      end
    end else begin
      d.pulse_cnt = '0;
    end

    // Suspend entry from the engine; set wins over a resume clear below, but a reset clear wins over set.
    if (ERASE_SUSPEND_IN) begin
      d.erase_susp = 1'b1;
      d.susp_op = ENGINE_OP_IN;
    end
    if (PROGRAM_SUSPEND_IN) begin
      d.program_susp = 1'b1;
    end
    if (ADDR_4BYTE_SET_IN) begin
      d.addr4 = 1'b1;
    end

    do_reset = 1'b0;
    unique case (q.state)
      ST_HOLD: begin
        d.pending = 1'b0;
        if (q.stable[SYN_PIN]) begin
          d.state = ST_RECOVER;
          d.load = 1'b1;
        end
      end
      ST_RECOVER: begin
        d.pending = 1'b0;
        if (!q.load && !tmr_running) begin
          d.state = ST_READY;
        end
      end
      ST_READY: begin
        if (cmd_done) begin
          d.armed = 1'b0;
          if (single) begin
            unique case (cmd)
              CMD_RESET_ARM: d.armed = 1'b1;
              CMD_NOP: d.armed = 1'b0;
              CMD_RESET: do_reset = q.armed;
              CMD_WRITE_LATCH_SET: d.write_latch = 1'b1;
              CMD_RESUME: begin
                // No write latch check here: resume stands on its own.
                if (!CONT_READ_IN &&
                    (q.erase_susp || q.program_susp)) begin
                  d.resume = 1'b1;
                  d.resume_hold = 1'b1;
                  d.erase_susp = ERASE_SUSPEND_IN;
                  d.program_susp = PROGRAM_SUSPEND_IN;
                end
              end
              default: d.armed = 1'b0;
            endcase
          end
        end
        if (do_reset) begin
          d.state = ST_RECOVER;
          d.load = 1'b1;
          d.rcv_kind = kind;
        end
      end
    endcase

    if (q.pulse_cnt == PULSE_W'(RESET_PULSE_CYC) && q.state != ST_HOLD) begin
      do_reset = 1'b1;
      d.state = ST_HOLD;
      d.load = 1'b0;
      d.rcv_kind = kind;
    end

    // Either reset wipes every volatile setting and aborts a busy or suspended engine.
    if (do_reset) begin
      d.abort = ENGINE_BUSY_IN || q.erase_susp || q.program_susp;
      d.armed = 1'b0;
      d.write_latch = 1'b0;
      d.erase_susp = 1'b0;
      d.program_susp = 1'b0;
      d.addr4 = 1'b0;
      d.resume = 1'b0;
      d.resume_hold = 1'b0;
      d.pending = 1'b0;
    end
    if ((ERASE_SUSPEND_IN || PROGRAM_SUSPEND_IN) && !do_reset) begin
      d.write_latch = 1'b0;
    end

    if (q.resume_hold && ENGINE_BUSY_IN) begin
      d.resume_hold = 1'b0;
    end
    // Busy covers the gap between resume and the engine's own busy.
    d.busy = ENGINE_BUSY_IN || d.resume_hold || d.state != ST_READY;

    // Low supply holds everything except the synchronisers and tog_seen in reset.
    if (!q.stable[SYN_POR]) begin
      d = '0;
      d.s1 = raw;
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.stable = q.stable;
      for (int i = 0; i < 4; i++) begin
        if (q.s2[i] == q.s3[i]) begin
          d.stable[i] = q.s3[i];
        end
      end
      d.tog_seen = q.stable[SYN_TOG];
      d.cs_prev = 1'b1;
      d.state = ST_RECOVER;
      d.load = 1'b1;
      d.rcv_kind = OP_READ;
      d.busy = 1'b1;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      q <= '0;
      q.s1 <= SYN_RESET;
      q.s2 <= SYN_RESET;
      q.s3 <= SYN_RESET;
      q.stable <= SYN_RESET;
      q.cs_prev <= 1'b1;
      q.state <= ST_RECOVER;
      q.load <= 1'b1;
      q.rcv_kind <= OP_READ;
      q.busy <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Serial output floats while the pin reset is held.
  assign SIO1_OE_N_OUT = so_oe_n || !q.stable[SYN_PIN] ||
                         q.state == ST_HOLD;
  assign BUSY_FLAG_OUT = q.busy;
  assign WRITE_LATCH_FLAG_OUT = q.write_latch;
  assign ERASE_SUSPEND_FLAG_OUT = q.erase_susp;
  assign PROGRAM_SUSPEND_FLAG_OUT = q.program_susp;
  assign ADDR_4BYTE_OUT = q.addr4;
  assign RESET_ARMED_OUT = q.armed;
  assign READY_OUT = (q.state == ST_READY);
  assign RESUME_OUT = q.resume;
  assign ABORT_OUT = q.abort;

endmodule

// [verification/frc_top_properties.sv]
`timescale 1ns/100ps
module frc_top_properties import frc_pkg::*; #(
  parameter logic [TMR_W-1:0] RCV_PROGRAM_CYCLES = 22'h000064
) (
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire logic POR_OK_IN,
  input wire logic ENGINE_BUSY_IN,
  input wire logic SIO1_OE_N_OUT,
  input wire logic BUSY_FLAG_OUT,
  input wire logic WRITE_LATCH_FLAG_OUT,
  input wire logic ERASE_SUSPEND_FLAG_OUT,
  input wire logic PROGRAM_SUSPEND_FLAG_OUT,
  input wire logic ADDR_4BYTE_OUT,
  input wire logic RESET_ARMED_OUT,
  input wire logic READY_OUT,
  input wire logic RESUME_OUT,
  input wire logic ABORT_OUT
);
  // ---------------------------------------------------------------
  // Length of the current spell without the ready flag
  // ---------------------------------------------------------------
  logic [TMR_W-1:0] low_cnt_q;
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN || READY_OUT) begin
      low_cnt_q <= '0;
    end else if (low_cnt_q != '1) begin
      low_cnt_q <= low_cnt_q + TMR_W'(1);
    end
  end

  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);

  sequence por_held;
    !POR_OK_IN [*6];
  endsequence
  sequence resume_seen;
    $rose(RESUME_OUT);
  endsequence

  chk_resume_needs_flag: assert property (resume_seen |->
    $past(ERASE_SUSPEND_FLAG_OUT, 2) || $past(PROGRAM_SUSPEND_FLAG_OUT, 2))
    else $error("resume issued with no suspend flag set");
  chk_resume_clears: assert property (resume_seen |-> ##[0:2]
    (!ERASE_SUSPEND_FLAG_OUT && !PROGRAM_SUSPEND_FLAG_OUT))
    else $error("suspend flags left set after resume");
  chk_resume_pulse: assert property (RESUME_OUT |=> !RESUME_OUT)
    else $error("resume pulse longer than one cycle");
  chk_busy_engine: assert property (ENGINE_BUSY_IN [*2] |-> BUSY_FLAG_OUT)
    else $error("busy flag low while engine runs");
  chk_busy_unready: assert property (!READY_OUT [*2] |-> BUSY_FLAG_OUT)
    else $error("busy flag low while not ready");
  chk_abort_resets: assert property (ABORT_OUT |-> ##[0:2]
    (!READY_OUT && !WRITE_LATCH_FLAG_OUT))
    else $error("abort without reset of state");
  chk_por_quiet: assert property (por_held |-> SIO1_OE_N_OUT &&
    !READY_OUT && !WRITE_LATCH_FLAG_OUT && !RESET_ARMED_OUT)
    else $error("logic active below supply threshold");
  chk_recover_min: assert property ($rose(READY_OUT) |->
    low_cnt_q >= RCV_PROGRAM_CYCLES)
    else $error("recovery shorter than shortest interval");
  chk_no_cmd_recover: assert property (!READY_OUT [*8] |->
    !$rose(RESET_ARMED_OUT) && !$rose(WRITE_LATCH_FLAG_OUT))
    else $error("command accepted during recovery");
  chk_addr_default: assert property ($rose(READY_OUT) |-> !ADDR_4BYTE_OUT)
    else $error("four byte addressing kept over reset");
  chk_reset_flags: assert property ($fell(READY_OUT) |-> ##[0:1]
    (!ERASE_SUSPEND_FLAG_OUT && !PROGRAM_SUSPEND_FLAG_OUT && !RESET_ARMED_OUT))
    else $error("flags kept over reset");
endmodule

bind frc_top frc_top_properties #(.RCV_PROGRAM_CYCLES(RCV_PROGRAM_CYCLES))
  u_props (.*);

// [verification/frc_host_model.sv]
`timescale 1ns/100ps
module frc_host_model (
  input wire logic quad_in,
  input wire logic so_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic [3:0] sio_out
);
  logic [7:0] rx_q;
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sio_out = 4'hA;
    rx_q = 8'h00;
  end
  // The link clock only runs inside a frame, 15 ns a period.
  task automatic tick();
    #7.5 sclk_out = 1'b1;
    rx_q = {rx_q[6:0], so_in};
    #7.5 sclk_out = 1'b0;
  endtask
  // Upper lines toggle in single mode so that listening to them shows.
  task automatic put_byte(input logic [7:0] b);
    int n;
    n = quad_in ? 2 : 8;
    for (int k = 0; k < n; k++) begin
      sio_out = quad_in ? b[7-4*k -: 4] : {~sio_out[3:1], b[7-k]};
      tick();
    end
  endtask
  task automatic frame(input logic [7:0] b [$], input int nrd,
                       output logic [7:0] rd [$]);
    rd = {};
    cs_n_out = 1'b0;
    #10;
    foreach (b[i]) put_byte(b[i]);
    repeat (nrd) begin
      repeat (8) tick();
      rd.push_back(rx_q);
    end
    #10 cs_n_out = 1'b1;
    sio_out = ~sio_out;
    #200;
  endtask
endmodule

// [verification/test_flash_resume_reset_control.sv]
`timescale 1ns/100ps
module test_flash_resume_reset_control import frc_pkg::*; ;
  logic clk, rst_n, pin_n, por_ok, cont, ebusy, esus, psus, a4set, quad;
  logic [2:0] eop;
  logic sclk, cs_n, so, oe_n, busy, wl, ef, pf, a4, arm, rdy, res, abt;
  logic [3:0] sio;
  logic [7:0] rd [$];
  int fail_count = 0;
  int checks = 0;
  int res_n = 0;
  int abt_n = 0;
  int low_n = 0;
  int last_low = 0;

`define CHK(nm, exp, got) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    fail_count++; \
    $display("BAD %s exp %0h got %0h", nm, exp, got); \
  end \
end

  frc_top #(.RCV_PROGRAM_CYCLES(22'h000064), .RCV_SECTOR_CYCLES(22'h000096),
    .RCV_BLOCK_CYCLES(22'h0000C8), .RCV_CHIP_CYCLES(22'h0000FA),
    .RCV_STATUS_CYCLES(22'h00012C)) dut (
    .CLOCK_IN(clk), .RST_N_IN(rst_n), .SCLK_IN(sclk), .CS_N_IN(cs_n),
    .SIO_IN(sio), .SIO1_OUT(so), .SIO1_OE_N_OUT(oe_n),
    .RESET_PIN_N_IN(pin_n), .POR_OK_IN(por_ok), .QUAD_MODE_IN(quad),
    .CONT_READ_IN(cont), .ENGINE_BUSY_IN(ebusy), .ENGINE_OP_IN(eop),
    .ERASE_SUSPEND_IN(esus), .PROGRAM_SUSPEND_IN(psus),
    .ADDR_4BYTE_SET_IN(a4set), .BUSY_FLAG_OUT(busy),
    .WRITE_LATCH_FLAG_OUT(wl), .ERASE_SUSPEND_FLAG_OUT(ef),
    .PROGRAM_SUSPEND_FLAG_OUT(pf), .ADDR_4BYTE_OUT(a4),
    .RESET_ARMED_OUT(arm), .READY_OUT(rdy), .RESUME_OUT(res),
    .ABORT_OUT(abt));
  frc_host_model host (.quad_in(quad), .so_in(so), .sclk_out(sclk),
    .cs_n_out(cs_n), .sio_out(sio));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Pulse counts and the last low spell of ready, seen at the clock edge.
  always @(posedge clk) begin
    if (res === 1'b1) res_n++;
    if (abt === 1'b1) abt_n++;
    if (rdy === 1'b0) low_n++;
    else if (low_n > 0) begin
      last_low = low_n;
      low_n = 0;
    end
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic cmd(input logic [7:0] op);
    host.frame({op}, 0, rd);
    cyc(8);
  endtask
  // The host waits out recovery before the next frame.
  task automatic wait_rdy(input int lim);
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
    cyc(2);
  endtask
  task automatic pulse(ref logic s);
    cyc(1);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic suspend_erase();
    ebusy = 1'b1;
    eop = OP_SECTOR_ERASE;
    pulse(esus);
    ebusy = 1'b0;
    eop = OP_READ;
    cyc(4);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_power();
    wait_rdy(2000);
    `CHK("boot_len", 1'b1, last_low > 1300 && last_low < 1500)
    `CHK("boot_wl", 1'b0, wl)
    por_ok = 1'b0;
    cyc(10);
    `CHK("por_ready", 1'b0, rdy)
    `CHK("por_oe_n", 1'b1, oe_n)
    cmd(CMD_WRITE_LATCH_SET);
    `CHK("por_wl", 1'b0, wl)
    por_ok = 1'b1;
    wait_rdy(2000);
    `CHK("por_wl2", 1'b0, wl)
    $display("power test done");
  endtask
  task automatic t_resume();
    int r0;
    suspend_erase();
    `CHK("esus_set", 1'b1, ef)
    r0 = res_n;
    cmd(CMD_RESUME);
    `CHK("res_pulse", r0 + 1, res_n)
    `CHK("res_ef", 1'b0, ef)
    `CHK("res_busy", 1'b1, busy)
    ebusy = 1'b1;
    cyc(4);
    `CHK("run_busy", 1'b1, busy)
    ebusy = 1'b0;
    cyc(4);
    `CHK("done_busy", 1'b0, busy)
    quad = 1'b1;
    cyc(400); // Resume-to-suspend latency.
    pulse(psus);
    cyc(4);
    `CHK("psus_set", 1'b1, pf)
    cmd(CMD_RESUME);
    `CHK("quad_pf", 1'b0, pf)
    `CHK("quad_pulse", r0 + 2, res_n)
    quad = 1'b0;
    pulse(ebusy);
    cyc(4);
    $display("resume test done");
  endtask
  task automatic t_contread();
    int r0;
    suspend_erase();
    r0 = res_n;
    cont = 1'b1;
    cmd(CMD_RESUME);
    `CHK("cr_ef", 1'b1, ef)
    `CHK("cr_pulse", r0, res_n)
    cont = 1'b0;
    cmd(CMD_RESUME);
    `CHK("cr_ef2", 1'b0, ef)
    pulse(ebusy);
    cyc(4);
    $display("continuous read test done");
  endtask
  task automatic t_nop();
    cmd(CMD_RESET_ARM);
    `CHK("arm_set", 1'b1, arm)
    cmd(CMD_NOP);
    `CHK("nop_arm", 1'b0, arm)
    cmd(CMD_RESET);
    `CHK("nop_rdy", 1'b1, rdy)
    cmd(CMD_RESET_ARM);
    cmd(CMD_WRITE_LATCH_SET);
    `CHK("mid_arm", 1'b0, arm)
    cmd(CMD_RESET);
    `CHK("mid_rdy", 1'b1, rdy)
    cmd(CMD_NOP);
    `CHK("nop_wl", 1'b1, wl)
    $display("no-operation test done");
  endtask
  task automatic t_soft();
    int a0;
    a0 = abt_n;
    ebusy = 1'b1;
    eop = OP_PROGRAM;
    cmd(CMD_RESET_ARM);
    cmd(CMD_RESET);
    `CHK("sr_abort", a0 + 1, abt_n)
    `CHK("sr_rdy", 1'b0, rdy)
    `CHK("sr_wl", 1'b0, wl)
    cmd(CMD_RESET_ARM);
    `CHK("sr_rej", 1'b0, arm)
    ebusy = 1'b0;
    eop = OP_IDLE;
    wait_rdy(400);
    `CHK("sr_prog", 1'b1, last_low >= 100 && last_low <= 106)
    suspend_erase();
    cmd(CMD_RESET_ARM);
    cmd(CMD_RESET);
    `CHK("es_abort", a0 + 2, abt_n)
    wait_rdy(2000);
    `CHK("es_sector", 1'b1, last_low >= 150 && last_low <= 156)
    `CHK("es_ef", 1'b0, ef)
    $display("software reset test done");
  endtask
  task automatic t_pin();
    int a0;
    pulse(a4set);
    cyc(2);
    `CHK("a4_set", 1'b1, a4)
    pin_n = 1'b0;
    cyc(100);
    pin_n = 1'b1;
    cyc(20);
    `CHK("short_rdy", 1'b1, rdy)
    a0 = abt_n;
    ebusy = 1'b1;
    eop = OP_PROGRAM;
    pin_n = 1'b0;
    cyc(420); // Held past the minimum pulse.
    `CHK("pin_rdy", 1'b0, rdy)
    `CHK("pin_oe_n", 1'b1, oe_n)
    `CHK("pin_abort", a0 + 1, abt_n)
    ebusy = 1'b0;
    eop = OP_IDLE;
    pin_n = 1'b1;
    cyc(400);
    wait_rdy(2000);
    `CHK("pin_a4", 1'b0, a4)
    `CHK("pin_busy", 1'b0, busy)
    `CHK("pin_wl", 1'b0, wl)
    $display("reset pin test done");
  endtask
  task automatic t_table();
    host.frame({CMD_PARAM_READ, 8'hA5, 8'h3C, 8'hF6, 8'hFF}, 3, rd);
    cyc(4);
    `CHK("tab0", PARAM_TABLE[6], rd[0])
    `CHK("tab1", PARAM_TABLE[7], rd[1])
    `CHK("tab2", PARAM_TABLE[0], rd[2])
    $display("table read test done");
  endtask

  initial begin
    rst_n = 1'b0;
    pin_n = 1'b1;
    por_ok = 1'b1;
    quad = 1'b0;
    cont = 1'b0;
    ebusy = 1'b0;
    eop = OP_IDLE;
    esus = 1'b0;
    psus = 1'b0;
    a4set = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    t_power();
    t_resume();
    t_contread();
    t_nop();
    t_soft();
    t_pin();
    t_table();
    end_sim();
  end
  initial begin
    #500000;
    fail_count++;
    end_sim();
  end
endmodule
